//--- hw/mic_regs.svh
// Register indices, field positions, reset values and timing of the motion interrupt controller.
// Assumes a 250 MHz core clock; byte address of a register is four times its index.
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// -----------------------------------------------------------------
// Register indices (byte address = index * 4)
// -----------------------------------------------------------------
`define MIC_IDX_ENABLE 6'h10
`define MIC_IDX_STATUS 6'h11
`define MIC_IDX_IRQ_STAT 6'h12
`define MIC_IDX_IRQ_MASK 6'h13
`define MIC_IDX_ROUTE_A 6'h19
`define MIC_IDX_ROUTE_B 6'h1B
`define MIC_IDX_SRC_SEL 6'h1E
`define MIC_IDX_POLARITY 6'h20
`define MIC_IDX_HOLD 6'h21

// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define MIC_ENG_NDATA 0
`define MIC_ENG_ORIENT 5
`define MIC_ENG_FLAT 6
`define MIC_SRC_MASK 8'h9F
`define MIC_HOLD_MODE_MASK 8'h0F
`define MIC_HOLD_CLR_BIT 7
`define MIC_POL_A_BIT 0
`define MIC_POL_B_BIT 1
`define MIC_POL_MASK 8'h03
`define MIC_POL_RST 8'h03
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

// -----------------------------------------------------------------
// Timing, in microseconds, and conversion to cycles
// -----------------------------------------------------------------
`define MIC_CLK_MHZ 250
`define MIC_US2CYC(us) (32'(64'(us) * 64'(`MIC_CLK_MHZ)))
`define MIC_T_250MS_US 250000
`define MIC_T_500MS_US 500000
`define MIC_T_1S_US 1000000
`define MIC_T_2S_US 2000000
`define MIC_T_4S_US 4000000
`define MIC_T_8S_US 8000000
`define MIC_T_250US_US 250
`define MIC_T_500US_US 500
`define MIC_T_1MS_US 1000
`define MIC_T_12MS5_US 12500
`define MIC_T_25MS_US 25000
`define MIC_T_50MS_US 50000
`define MIC_T_AUTO_CLR_US 12500
`define MIC_T_NDATA_LOW_US 50

`endif

//--- hw/mic_pkg.sv
// Types shared by the motion interrupt controller modules.
// Assumes mic_regs.svh is on the include path.
`include "mic_regs.svh"

package mic_pkg;

  typedef enum logic [1:0] {
    MIC_HK_NONLATCH = 2'b00,
    MIC_HK_TEMP = 2'b01,
    MIC_HK_LATCH = 2'b10
  } mic_hold_kind_t;

  // Hold-mode code to kind
  function automatic mic_hold_kind_t mic_hold_kind(input logic [3:0] code);
    case (code)
      4'h0, 4'h8: mic_hold_kind = MIC_HK_NONLATCH;
      4'h7, 4'hF: mic_hold_kind = MIC_HK_LATCH;
      default: mic_hold_kind = MIC_HK_TEMP;
    endcase
  endfunction

  typedef struct packed {
    logic [7:0] st;
    logic [7:0][31:0] cnt;
  } mic_bank_state_t;

  typedef struct packed {
    logic pin_a;
    logic pin_b;
  } mic_pin_state_t;

  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [7:0] src;
    logic [7:0] pol;
    logic [3:0] mode;
    logic clr_latch;
    logic [7:0] en;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] prev;
    logic irq;
  } mic_top_state_t;

endpackage

//--- hw/mic_ctl_if.sv
// Control and status bundle between the controller top, the engine bank and the pin driver.
// Assumes all parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface mic_ctl_if;
  import mic_pkg::*;
  logic [7:0] en;
  logic [7:0] cond;
  logic update;
  logic acq_start;
  mic_hold_kind_t hold_kind;
  logic [31:0] tmo_cyc;
  logic clr_latch;
  logic [7:0] status;
  logic [7:0] route_a;
  logic [7:0] route_b;
  logic pol_a;
  logic pol_b;
  logic pin_a;
  logic pin_b;

  modport top (output en, cond, update, acq_start, hold_kind, tmo_cyc, clr_latch,
               route_a, route_b, pol_a, pol_b, input status, pin_a, pin_b);
  modport bank (input en, cond, update, acq_start, hold_kind, tmo_cyc, clr_latch, output status);
  modport pins (input status, route_a, route_b, pol_a, pol_b, output pin_a, pin_b);
endinterface

`default_nettype wire

//--- hw/mic_engine_bank.sv
// Status bits and hold timers of the eight interrupt engines.
// Assumes cond is the engines' activation level and update pulses once per stored sample.
`timescale 1ns/1ps
`default_nettype none

`include "mic_regs.svh"

module mic_engine_bank
  import mic_pkg::*;
#(
  parameter logic [31:0] AUTO_CLR_CYC = `MIC_US2CYC(`MIC_T_AUTO_CLR_US),
  parameter logic [31:0] ND_LOW_CYC = `MIC_US2CYC(`MIC_T_NDATA_LOW_US)
) (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  mic_ctl_if.bank ctl // Configuration in, status out
);

  mic_bank_state_t s_r;
  mic_bank_state_t s_nxt;

  always_comb begin
    logic timed;
    logic fixed;
    timed = 1'b0;
    fixed = 1'b0;
    s_nxt = s_r;
    for (int i = 0; i < 8; i++) begin
      fixed = (i == `MIC_ENG_ORIENT) || (i == `MIC_ENG_FLAT);
      timed = fixed || (ctl.hold_kind == MIC_HK_TEMP);
      if (!ctl.en[i]) begin
        s_nxt.st[i] = 1'b0;
        s_nxt.cnt[i] = '0;
      end else if (i == `MIC_ENG_NDATA) begin
        if (s_r.cnt[i] != '0) begin
          s_nxt.cnt[i] = s_r.cnt[i] - 32'h1;
        end
        if (ctl.acq_start && s_r.st[i]) begin
          s_nxt.st[i] = 1'b0;
          s_nxt.cnt[i] = ND_LOW_CYC; // Guard keeps status low for the minimum time
        end else if (ctl.update && ctl.cond[i] && (s_r.cnt[i] == '0)) begin
          s_nxt.st[i] = 1'b1;
        end
      end else begin
        if (s_r.st[i] && (s_r.cnt[i] != '0)) begin
          s_nxt.cnt[i] = s_r.cnt[i] - 32'h1;
        end
        if (timed) begin
          // Expired hold still waits for the condition to drop
          if (s_r.st[i] && (s_r.cnt[i] == '0) && !ctl.cond[i]) begin
            s_nxt.st[i] = 1'b0;
          end
        end else if (ctl.hold_kind == MIC_HK_NONLATCH) begin
          if (ctl.update && !ctl.cond[i]) begin
            s_nxt.st[i] = 1'b0;
          end
        end else if (ctl.clr_latch) begin
          s_nxt.st[i] = 1'b0;
        end
        // Set after clears, so a new event wins over a clear
        if (ctl.update && ctl.cond[i]) begin
          s_nxt.st[i] = 1'b1;
          if (!s_r.st[i]) begin
            s_nxt.cnt[i] = fixed ? AUTO_CLR_CYC : ctl.tmo_cyc;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ctl.status = s_r.st;

endmodule

`default_nettype wire

//--- hw/mic_pin_drv.sv
// Routing OR and polarity of the two interrupt pins, registered.
// Assumes push-pull pins; idle level is the inverse of the polarity bit.
`timescale 1ns/1ps
`default_nettype none

module mic_pin_drv
  import mic_pkg::*;
(
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  mic_ctl_if.pins ctl // Status and routing in, pins out
);

  mic_pin_state_t s_r;
  mic_pin_state_t s_nxt;

  always_comb begin
    s_nxt.pin_a = (|(ctl.status & ctl.route_a)) ~^ ctl.pol_a;
    s_nxt.pin_b = (|(ctl.status & ctl.route_b)) ~^ ctl.pol_b;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ctl.pin_a = s_r.pin_a;
  assign ctl.pin_b = s_r.pin_b;

endmodule

`default_nettype wire

//--- hw/mic_top.sv
// Motion interrupt controller: AXI4-Lite register file, eight engines, two interrupt pins.
// Assumes detection engines outside drive engine_cond, and the sample path pulses
// accel_update when a new acceleration word is stored and acq_start when acquisition begins.
//
// Functional notes
// - Eight interrupt engines, each enabled on its own; one hold code is shared by all.
// - Enabled engine's condition true sets its status and drives its routed pins.
// - Two pins; each is the OR of every engine routed to it.
// - Status is set only when a new acceleration word is stored.
// - Disabling an engine clears its status at once.
// - One four-bit hold code for all: 0/8 non-latched, 7/F latched, others temporary.
// - Temporary mode clears after the hold time the code selects.
// - An interrupt stays asserted while its condition holds, in non-latched and temporary modes.
// - Non-latched status drops on the first update after the condition ends.
// - Orientation and flat engines clear after their own fixed time.
// - Latched status holds until software writes the clear bit.
// - Latched interrupt cleared under a live condition re-asserts on next update.
// - Data, tap, slow-motion, slope and low-g engines choose filtered or unfiltered input.
// - Orientation and flat engines always take filtered input.
// - One routing register for pin A, another for pin B; one connects.
// - Each pin's polarity bit: one active high, zero active low.
// - New-data asserts on a stored sample, clears at next acquisition, low 50us minimum.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

`include "mic_regs.svh"

module mic_top
  import mic_pkg::*;
#(
  parameter int unsigned HOLD_CYC [16] = '{
    32'd0,
    `MIC_US2CYC(`MIC_T_250MS_US),
    `MIC_US2CYC(`MIC_T_500MS_US),
    `MIC_US2CYC(`MIC_T_1S_US),
    `MIC_US2CYC(`MIC_T_2S_US),
    `MIC_US2CYC(`MIC_T_4S_US),
    `MIC_US2CYC(`MIC_T_8S_US),
    32'd0,
    32'd0,
    `MIC_US2CYC(`MIC_T_250US_US),
    `MIC_US2CYC(`MIC_T_500US_US),
    `MIC_US2CYC(`MIC_T_1MS_US),
    `MIC_US2CYC(`MIC_T_12MS5_US),
    `MIC_US2CYC(`MIC_T_25MS_US),
    `MIC_US2CYC(`MIC_T_50MS_US),
    32'd0
  },
  parameter logic [31:0] AUTO_CLR_CYC = `MIC_US2CYC(`MIC_T_AUTO_CLR_US),
  parameter logic [31:0] ND_LOW_CYC = `MIC_US2CYC(`MIC_T_NDATA_LOW_US)
) (
  input wire logic aclk, // Core clock, 250 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:0] engine_cond, // Activation level per engine
  input wire logic accel_update, // Pulse: new acceleration word stored
  input wire logic acq_start, // Pulse: next acquisition cycle starts
  output logic [7:0] engine_src_unfilt, // Per engine: 1 = unfiltered input
  output logic first_irq_pin, // Interrupt pin A
  output logic second_irq_pin, // Interrupt pin B
  output logic irq // Level interrupt to the local CPU
);

  // -----------------------------------------------------------------
  // Shared bundle and submodules
  // -----------------------------------------------------------------
  mic_ctl_if ctl ();

  mic_engine_bank #(
    .AUTO_CLR_CYC(AUTO_CLR_CYC),
    .ND_LOW_CYC(ND_LOW_CYC)
  ) u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(ctl.bank)
  );

  mic_pin_drv u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(ctl.pins)
  );

  // -----------------------------------------------------------------
  // Register index decode
  // -----------------------------------------------------------------
  function automatic logic reg_known(input logic [5:0] idx);
    case (idx)
      `MIC_IDX_ENABLE,
      `MIC_IDX_STATUS,
      `MIC_IDX_IRQ_STAT,
      `MIC_IDX_IRQ_MASK,
      `MIC_IDX_ROUTE_A,
      `MIC_IDX_ROUTE_B,
      `MIC_IDX_SRC_SEL,
      `MIC_IDX_POLARITY,
      `MIC_IDX_HOLD: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  mic_top_state_t s_r;
  mic_top_state_t s_nxt;

  always_comb begin
    logic [7:0] w1c;
    logic [7:0] rise;
    logic [7:0] rd;
    logic [5:0] ridx;
    w1c = 8'h00;
    rise = 8'h00;
    rd = 8'h00;
    ridx = s_axi_araddr[7:2];
    s_nxt = s_r;
    s_nxt.clr_latch = 1'b0;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && !s_r.aw_held) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && !s_r.w_held) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Commit once both halves are held and the previous response is gone
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_known(s_r.aw_idx) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      if (s_r.w_lane0) begin
        case (s_r.aw_idx)
          `MIC_IDX_ENABLE: begin
            s_nxt.en = s_r.w_data;
          end
          `MIC_IDX_IRQ_STAT: begin
            w1c = s_r.w_data;
          end
          `MIC_IDX_IRQ_MASK: begin
            s_nxt.irq_mask = s_r.w_data;
          end
          `MIC_IDX_ROUTE_A: begin
            s_nxt.route_a = s_r.w_data;
          end
          `MIC_IDX_ROUTE_B: begin
            s_nxt.route_b = s_r.w_data;
          end
          `MIC_IDX_SRC_SEL: begin
            // Orientation and flat bits cannot be set
            s_nxt.src = s_r.w_data & `MIC_SRC_MASK;
          end
          `MIC_IDX_POLARITY: begin
            s_nxt.pol = s_r.w_data & `MIC_POL_MASK;
          end
          `MIC_IDX_HOLD: begin
            s_nxt.mode = s_r.w_data[3:0];
            s_nxt.clr_latch = s_r.w_data[`MIC_HOLD_CLR_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    // Sticky event bits; a rising edge in the clear cycle survives
    rise = ctl.status & ~s_r.prev;
    s_nxt.prev = ctl.status;
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | rise;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Read channel: one read outstanding, answered the cycle after it is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      case (ridx)
        `MIC_IDX_ENABLE: rd = s_r.en;
        `MIC_IDX_STATUS: rd = ctl.status;
        `MIC_IDX_IRQ_STAT: rd = s_r.irq_stat;
        `MIC_IDX_IRQ_MASK: rd = s_r.irq_mask;
        `MIC_IDX_ROUTE_A: rd = s_r.route_a;
        `MIC_IDX_ROUTE_B: rd = s_r.route_b;
        `MIC_IDX_SRC_SEL: rd = s_r.src;
        `MIC_IDX_POLARITY: rd = s_r.pol;
        // Clear bit is a strobe and reads as zero
        `MIC_IDX_HOLD: rd = {4'h0, s_r.mode};
        default: rd = 8'h00;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = reg_known(ridx) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.pol <= `MIC_POL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Bundle drive
  // -----------------------------------------------------------------
  assign ctl.en = s_r.en;
  assign ctl.cond = engine_cond;
  assign ctl.update = accel_update;
  assign ctl.acq_start = acq_start;
  assign ctl.hold_kind = mic_hold_kind(s_r.mode);
  // Non-temporary codes map to zero, and that zero is still loaded into an engine's timer when it sets
  assign ctl.tmo_cyc = HOLD_CYC[s_r.mode];
  assign ctl.clr_latch = s_r.clr_latch;
  assign ctl.route_a = s_r.route_a;
  assign ctl.route_b = s_r.route_b;
  assign ctl.pol_a = s_r.pol[`MIC_POL_A_BIT];
  assign ctl.pol_b = s_r.pol[`MIC_POL_B_BIT];

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign s_axi_awready = !s_r.aw_held;
  assign s_axi_wready = !s_r.w_held;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = {24'h000000, s_r.rdata};
  assign s_axi_rresp = s_r.rresp;
  assign engine_src_unfilt = s_r.src;
  assign first_irq_pin = ctl.pin_a;
  assign second_irq_pin = ctl.pin_b;
  assign irq = s_r.irq;

endmodule

`default_nettype wire

//--- test/mic_irq_monitor.sv
// Port checker for the motion interrupt controller, bound to its top module.
// Assumes one clock; reads answer one cycle after the take, writes two cycles after both halves.
`timescale 1ns/1ps
`default_nettype none

module mic_irq_monitor (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [7:0] engine_src_unfilt, // Sources
  input wire logic first_irq_pin, // Pin A
  input wire logic second_irq_pin, // Pin B
  input wire logic irq // CPU interrupt
);
  default clocking mcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_turn: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_turn: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_arready_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_bresp_code: assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response");
  a_src_fixed: assert property (
    engine_src_unfilt[6:5] == 2'b00)
    else $error("pose engines not on filtered data");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !irq && !first_irq_pin && !second_irq_pin)
    else $error("outputs active after reset");

  c_pin_a: cover property ($rose(first_irq_pin));
  c_pin_b: cover property ($rose(second_irq_pin));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind mic_top mic_irq_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .engine_src_unfilt(engine_src_unfilt),
  .first_irq_pin(first_irq_pin), .second_irq_pin(second_irq_pin), .irq(irq)
);

`default_nettype wire

//--- test/mic_host_model.sv
// Host side of the two interrupt pins: decodes each pin's active level.
// Assumes the bench tells it the polarity it has programmed.
`timescale 1ns/1ps
`default_nettype none

module mic_host_model (
  input wire logic aclk, // Clock
  input wire logic pin_a, // First pin
  input wire logic pin_b, // Second pin
  input wire logic [1:0] pol, // Programmed polarity
  output logic act_a, // Pin A asserted
  output logic act_b // Pin B asserted
);
  // Registered like a synchronous host input, so one cycle behind the pins
  always_ff @(posedge aclk) begin
    act_a <= (pin_a == pol[0]);
    act_b <= (pin_b == pol[1]);
  end
endmodule

`default_nettype wire

//--- test/tb_motion_irq_controller.sv
// Self-checking bench for the motion interrupt controller.
// Assumes shortened hold, auto-clear and new-data counts set below.
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.svh"

module tb_motion_irq_controller;
  localparam int unsigned HC [16] = '{0, 40, 40, 40, 40, 40, 40, 0, 0, 20, 20, 20, 20, 20, 20, 0};
  localparam logic [5:0] EN = `MIC_IDX_ENABLE, ST = `MIC_IDX_STATUS, IS = `MIC_IDX_IRQ_STAT;
  localparam logic [5:0] IM = `MIC_IDX_IRQ_MASK, RA = `MIC_IDX_ROUTE_A, RB = `MIC_IDX_ROUTE_B;
  localparam logic [5:0] SS = `MIC_IDX_SRC_SEL, PO = `MIC_IDX_POLARITY, HO = `MIC_IDX_HOLD;
  localparam logic [1:0] OK = `MIC_RESP_OKAY, ER = `MIC_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic upd_p = 1'b0, acq = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cond = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] stb = 4'hF;
  logic [1:0] pol = 2'b11;
  wire awr, wrd, bv, arr, rv, pa, pb, irq, act_a, act_b;
  wire [1:0] br, rr;
  wire [31:0] rdata;
  wire [7:0] src;
  int err_total = 0;
  int n_checks = 0;

  always #2 aclk = ~aclk;

  mic_top #(.HOLD_CYC(HC), .AUTO_CLR_CYC(32'd30), .ND_LOW_CYC(32'd10)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(stb), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .engine_cond(cond), .accel_update(upd_p), .acq_start(acq), .engine_src_unfilt(src),
    .first_irq_pin(pa), .second_irq_pin(pb), .irq(irq));

  mic_host_model host (.aclk(aclk), .pin_a(pa), .pin_b(pb), .pol(pol), .act_a(act_a), .act_b(act_b));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    err_total++;
    $display("[ERR] %0t bus answer never came", $time);
    wrap_up();
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er);
    int n;
    awaddr <= {ix, 2'b00};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 64) tmo();
    chk(br, er);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [5:0] ix, input logic [7:0] exp, input logic [1:0] er);
    int n;
    araddr <= {ix, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 64) tmo();
    chk(rdata, {24'h000000, exp});
    chk(rr, er);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Status samples cond on the pulse; pins settle one edge later, host view two
  task automatic upd(input logic [7:0] c);
    cond <= c;
    upd_p <= 1'b1;
    @(posedge aclk);
    upd_p <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(PO, 8'h03, OK);
    rdc(HO, 8'h00, OK);
    wr(RA, 8'hA5, OK);
    rdc(RA, 8'hA5, OK);
    wr(SS, 8'hFF, OK);
    rdc(SS, 8'h9F, OK);
    chk(src, 8'h9F);
    stb <= 4'h0;
    wr(RB, 8'h5A, OK);
    stb <= 4'hF;
    rdc(RB, 8'h00, OK);
    wr(6'h3F, 8'h01, ER);
    rdc(6'h3F, 8'h00, ER);
    $display("t_regs done");
  endtask

  task automatic t_route;
    wr(RA, 8'h02, OK);
    wr(RB, 8'h06, OK);
    wr(EN, 8'h06, OK);
    upd(8'h02);
    rdc(ST, 8'h02, OK);
    chk({act_a, act_b}, 2'b11);
    cond <= 8'h04;
    repeat (4) @(posedge aclk);
    rdc(ST, 8'h02, OK);
    upd(8'h04);
    rdc(ST, 8'h04, OK);
    chk({act_a, act_b}, 2'b01);
    wr(PO, 8'h00, OK);
    pol <= 2'b00;
    repeat (2) @(posedge aclk);
    chk({pa, pb}, 2'b10);
    chk({act_a, act_b}, 2'b01);
    wr(PO, 8'h03, OK);
    pol <= 2'b11;
    upd(8'h00);
    rdc(ST, 8'h00, OK);
    chk({act_a, act_b}, 2'b00);
    $display("t_route done");
  endtask

  task automatic t_modes;
    int k;
    for (k = 0; k < 16; k++) begin
      wr(EN, 8'h00, OK);
      wr(HO, 8'(k), OK);
      wr(EN, 8'h02, OK);
      upd(8'h02);
      if (k == 0 || k == 8) begin
        upd(8'h00);
        rdc(ST, 8'h00, OK);
      end else if (k == 7 || k == 15) begin
        upd(8'h00);
        rdc(ST, 8'h02, OK);
        cond <= 8'h02;
        wr(HO, 8'(k) | 8'h80, OK);
        rdc(ST, 8'h00, OK);
        upd(8'h02);
        rdc(ST, 8'h02, OK);
        wr(EN, 8'h00, OK);
        rdc(ST, 8'h00, OK);
      end else begin
        upd(8'h00);
        rdc(ST, 8'h02, OK);
        repeat (HC[k]) @(posedge aclk);
        rdc(ST, 8'h00, OK);
      end
    end
    $display("t_modes done");
  endtask

  task automatic t_irq;
    wr(HO, 8'h07, OK);
    wr(IM, 8'h00, OK);
    // Earlier scenarios left sticky rises behind
    wr(IS, 8'hFF, OK);
    rdc(IS, 8'h00, OK);
    wr(EN, 8'h02, OK);
    upd(8'h02);
    rdc(IS, 8'h02, OK);
    chk(irq, 1'b0);
    wr(IM, 8'h02, OK);
    @(posedge aclk);
    chk(irq, 1'b1);
    wr(IS, 8'h02, OK);
    @(posedge aclk);
    rdc(IS, 8'h00, OK);
    chk(irq, 1'b0);
    wr(EN, 8'h00, OK);
    $display("t_irq done");
  endtask

  task automatic t_nd;
    wr(EN, 8'h21, OK);
    upd(8'h21);
    rdc(ST, 8'h21, OK);
    acq <= 1'b1;
    @(posedge aclk);
    acq <= 1'b0;
    upd(8'h21);
    rdc(ST, 8'h20, OK);
    repeat (12) @(posedge aclk);
    upd(8'h21);
    rdc(ST, 8'h21, OK);
    repeat (36) @(posedge aclk);
    rdc(ST, 8'h21, OK);
    cond <= 8'h00;
    repeat (4) @(posedge aclk);
    rdc(ST, 8'h01, OK);
    $display("t_nd done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_route();
    t_modes();
    t_irq();
    t_nd();
    wrap_up();
  end
endmodule

`default_nettype wire
